// File: design/cta_top.sv
// Current telemetry, phase balance, overcurrent, droop and input power alert logic
//
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module cta_top
  import cta_pkg::*;
#(
  parameter int HOLD_CYC = CTA_ALERT_HOLD_CYC
) (
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_rstn,
  // Avalon-MM slave
  input  wire cta_avs_req_t     i_avs,
  output logic [31:0]           o_avs_readdata,
  output logic                  o_avs_waitrequest,
  // Enable pin and PWM path
  input  wire logic             i_en,
  input  wire logic             i_ramp_active,
  input  wire logic [7:0]       i_pwm_raw,
  output logic [7:0]            o_pwm,
  output logic [7:0]            o_pwm_oe_n,
  // Monitoring converter
  output logic [2:0]            o_mux_sel,
  input  wire logic [11:0]      i_mon_code,
  input  wire logic             i_mon_valid,
  // Input current and voltage converter
  input  wire logic [11:0]      i_iin_code,
  input  wire logic [11:0]      i_vin_code,
  input  wire logic             i_iin_valid,
  // Control loop side
  input  wire logic             i_fast_transient,
  input  wire logic [1:0][15:0] i_voltage_setpoint_reference,
  output logic [1:0][15:0]      o_droop_voltage_positioning,
  output cta_bal_t              o_bal,
  output logic [1:0]            o_oc,
  output logic [1:0][15:0]      o_iout,
  // Power alert open-drain pin
  output logic                  o_alert_o,
  output logic                  o_alert_oe_n
);

  logic             rst_s1_r;
  logic             rst_s2_r;
  cta_state_t       st_r;
  cta_state_t       st_nxt;
  logic [3:0]       n1;
  logic [1:0]       n2;
  logic [7:0]       act;
  logic [1:0][14:0] tot;
  logic [1:0][15:0] iout_v;
  logic [1:0][14:0] avg;
  logic [31:0]      rd_val;
  logic [11:0]      adj;
  logic [16:0]      fdiff;
  logic [26:0]      pin_f;
  logic [37:0]      pdiff;
  logic             above;
  logic             below90;
  logic [15:0]      min_v;
  logic [2:0]       min_i;
  logic [16:0]      tgt;
  logic [14:0]      iin;

  // Scaled product with a 1/128 unity point, saturating
  function automatic logic [15:0] cta_scale(input logic [15:0] a, input logic [7:0] k);
    logic [23:0] p;
    p = 24'(a) * 24'(k);
    return p[23] ? 16'hffff : p[22:7];
  endfunction

  // Phase membership of loop 0 (first n1) or loop 1 (next n2)
  function automatic logic cta_in_loop(input int ph, input logic [3:0] a, input logic [1:0] b,
                                       input logic lp);
    if (!lp)
      return ph < int'(a);
    return (ph >= int'(a)) && (ph < int'(a) + int'(b));
  endfunction

  // Reset release through two flops
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  assign n1 = st_r.ctrl[CTA_CTRL_N1_LSB +: 4];
  assign n2 = st_r.ctrl[CTA_CTRL_N2_LSB +: 2];
  assign pin_f = st_r.pin_acc[36 -: 27];

  // Loop totals, true current, averages and fast-balance candidate
  always_comb begin
    tot   = '0;
    act   = '0;
    min_v = 16'hffff;
    min_i = 3'h0;
    for (int i = 0; i < CTA_NPH; i++) begin
      for (int l = 0; l < 2; l++) begin
        if (cta_in_loop(i, n1, n2, l[0])) begin
          act[i] = 1'b1;
          tot[l] = tot[l] + 15'(st_r.filt[i][15:4]);
        end
      end
      if (cta_in_loop(i, n1, n2, 1'b0) && st_r.filt[i] < min_v) begin
        min_v = st_r.filt[i];
        min_i = 3'(i);
      end
    end
    for (int l = 0; l < 2; l++) begin
      iout_v[l] = cta_scale({1'b0, tot[l]}, st_r.llcfg[CTA_LL_SCALE_LSB +: 8]);
      if (l == 0)
        avg[l] = (n1 == 4'h0) ? 15'h0 : 15'(tot[l] / 15'(n1));
      else
        avg[l] = (n2 == 2'h0) ? 15'h0 : 15'(tot[l] / 15'(n2));
    end
  end

  // Register read mux; unmapped words read as zero
  always_comb begin
    rd_val = 32'h0;
    case (i_avs.address[7:5])
      CTA_GAIN_BLK: rd_val = 32'(st_r.gain[i_avs.address[4:2]]);
      CTA_OFS_BLK:  rd_val = 32'(st_r.ofs[i_avs.address[4:2]]);
      CTA_PHI_BLK:  rd_val = 32'(st_r.filt[i_avs.address[4:2]]);
      3'h0, 3'h1: begin
        case (i_avs.address)
          CTA_CTRL_OFS:   rd_val = 32'(st_r.ctrl);
          CTA_RANGE_OFS:  rd_val = 32'(st_r.rng_cfg);
          CTA_PTHR_OFS:   rd_val = 32'(st_r.pthr);
          CTA_OCTHR_OFS:  rd_val = st_r.octhr;
          CTA_LLCFG_OFS:  rd_val = 32'(st_r.llcfg);
          CTA_STATUS_OFS: rd_val = {25'h0, st_r.en_s2, st_r.rng, st_r.bal.fast_active,
                                    st_r.oc, ~st_r.alert_oe_n};
          CTA_PVAL_OFS:   rd_val = 32'(pin_f);
          CTA_IOUT1_OFS:  rd_val = 32'(st_r.iout[0]);
          CTA_IOUT2_OFS:  rd_val = 32'(st_r.iout[1]);
          default:        rd_val = 32'h0;
        endcase
      end
      default: rd_val = 32'h0;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    // Enable pin synchroniser; only the second stage and its delayed copy are looked at
    st_nxt.en_s1 = i_en;
    st_nxt.en_s2 = st_r.en_s1;
    st_nxt.en_q  = st_r.en_s2;
    if (st_r.en_s2 && !st_r.en_q)
      st_nxt.rng = st_r.rng_cfg;

    // Bus: one wait cycle, then the transfer completes
    st_nxt.ack = (i_avs.read || i_avs.write) && !st_r.ack;
    if (i_avs.read && !st_r.ack)
      st_nxt.rdata = rd_val;
    if (i_avs.write && st_r.ack) begin
      case (i_avs.address[7:5])
        CTA_GAIN_BLK: st_nxt.gain[i_avs.address[4:2]] = i_avs.writedata[5:0];
        CTA_OFS_BLK:  st_nxt.ofs[i_avs.address[4:2]] = i_avs.writedata[11:0];
        3'h0: begin
          case (i_avs.address)
            CTA_CTRL_OFS:  st_nxt.ctrl = i_avs.writedata[6:0];
            CTA_RANGE_OFS: st_nxt.rng_cfg = i_avs.writedata[1:0];
            CTA_PTHR_OFS:  st_nxt.pthr = i_avs.writedata[26:0];
            CTA_OCTHR_OFS: st_nxt.octhr = i_avs.writedata;
            CTA_LLCFG_OFS: st_nxt.llcfg = i_avs.writedata[23:0];
            default:       st_nxt.ctrl = st_r.ctrl;
          endcase
        end
        default: st_nxt.ctrl = st_r.ctrl;
      endcase
    end

    // PWM drive only while enabled and ramping on a configured phase
    st_nxt.pwm = i_pwm_raw;
    for (int i = 0; i < CTA_NPH; i++)
      st_nxt.pwm_oe_n[i] = !(st_r.en_s2 && i_ramp_active && act[i]);

    // Shared converter walks the configured phases in turn
    adj   = 12'h0;
    fdiff = 17'h0;
    if (i_mon_valid) begin
      adj = (i_mon_code > st_r.ofs[st_r.mux_sel]) ?
            i_mon_code - st_r.ofs[st_r.mux_sel] : 12'h0;
      fdiff = {1'b0, adj, 4'h0} - {1'b0, st_r.filt[st_r.mux_sel]};
      st_nxt.filt[st_r.mux_sel] = st_r.filt[st_r.mux_sel] +
                                  16'($signed(fdiff) >>> CTA_PH_SH);
      if (4'(st_r.mux_sel) + 4'h1 >= 4'(n1) + 4'(n2))
        st_nxt.mux_sel = 3'h0;
      else
        st_nxt.mux_sel = st_r.mux_sel + 3'h1;
    end

    // Telemetry, overcurrent and droop per loop
    for (int l = 0; l < 2; l++) begin
      st_nxt.iout[l] = iout_v[l];
      st_nxt.oc[l]   = iout_v[l] > st_r.octhr[16*l +: 16];
      st_nxt.droop[l] = i_voltage_setpoint_reference[l] +
                        (st_r.ctrl[CTA_CTRL_LLEN] ?
                         cta_scale(iout_v[l], st_r.llcfg[8*l +: 8]) : 16'h0);
    end

    // Balance: each configured phase is steered towards its loop average, skewed by its gain
    tgt = 17'h0;
    for (int i = 0; i < CTA_NPH; i++) begin
      tgt = {2'b0, avg[cta_in_loop(i, n1, n2, 1'b1)]};
      // Product kept at 23 bits so a large target with a large gain cannot wrap
      tgt = tgt + 17'(($signed(23'(tgt)) *
                       $signed(23'($signed(st_r.gain[i])))) >>> 5);
      st_nxt.bal.trim[i] = act[i] ? 13'(tgt - {5'b0, st_r.filt[i][15:4]}) : 13'h0;
    end
    // Lightest loop 0 phase fires first during fast transients
    st_nxt.bal.fast_active = i_fast_transient;
    st_nxt.bal.first_phase = i_fast_transient ? min_i : 3'h0;

    // Input power, range set by shift so each range halves the last
    iin = 15'h0;
    if (i_iin_valid) begin
      iin = 15'({3'h0, i_iin_code} << (2'h3 - st_r.rng));
      st_nxt.pin_raw = 27'(iin * i_vin_code);
    end
    pdiff = {1'b0, st_r.pin_raw, 10'h0} - {1'b0, st_r.pin_acc};
    st_nxt.pin_acc = st_r.pin_acc + 37'($signed(pdiff) >>> CTA_PIN_SH);

    // Alert with ninety percent release and a hold before letting go
    above   = pin_f > st_r.pthr;
    below90 = (31'(pin_f) * 31'd10) < (31'(st_r.pthr) * 31'd9);
    case (st_r.al_st)
      CTA_AL_IDLE: begin
        if (above) begin
          st_nxt.al_st = CTA_AL_ASSERT;
          st_nxt.alert_oe_n = 1'b0;
        end
      end
      CTA_AL_ASSERT: begin
        if (below90) begin
          st_nxt.al_st = CTA_AL_HOLD;
          st_nxt.hold_cnt = 24'h0;
        end
      end
      CTA_AL_HOLD: begin
        if (!below90)
          st_nxt.al_st = CTA_AL_ASSERT;
        else if (st_r.hold_cnt >= 24'(HOLD_CYC - 1)) begin
          st_nxt.al_st = CTA_AL_IDLE;
          st_nxt.alert_oe_n = 1'b1;
        end else
          st_nxt.hold_cnt = st_r.hold_cnt + 24'h1;
      end
      default: begin
        st_nxt.al_st = CTA_AL_IDLE;
        st_nxt.alert_oe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      st_r            <= '0;
      st_r.ctrl       <= CTA_CTRL_RST;
      st_r.rng        <= CTA_RANGE_RST;
      st_r.rng_cfg    <= CTA_RANGE_RST;
      st_r.pthr       <= CTA_PTHR_RST;
      st_r.octhr      <= CTA_OCTHR_RST;
      st_r.llcfg      <= CTA_LLCFG_RST;
      st_r.al_st      <= CTA_AL_IDLE;
      st_r.alert_oe_n <= 1'b1;
      st_r.pwm_oe_n   <= 8'hff;
    end else
      st_r <= st_nxt;
  end

  // Waitrequest drops one cycle after the request is seen
  assign o_avs_waitrequest            = (i_avs.read || i_avs.write) && !st_r.ack;
  assign o_avs_readdata               = st_r.rdata;
  assign o_pwm                        = st_r.pwm;
  assign o_pwm_oe_n                   = st_r.pwm_oe_n;
  assign o_mux_sel                    = st_r.mux_sel;
  assign o_droop_voltage_positioning  = st_r.droop;
  assign o_bal                        = st_r.bal;
  assign o_oc                         = st_r.oc;
  assign o_iout                       = st_r.iout;
  assign o_alert_o                    = 1'b0;
  assign o_alert_oe_n                 = st_r.alert_oe_n;

endmodule

// File: design/cta_pkg.sv
// Constants, register map and carrier types of the current telemetry and power alert block
package cta_pkg;
  // Register byte offsets and block numbers
  localparam logic [7:0] CTA_CTRL_OFS    = 8'h00;
  localparam logic [7:0] CTA_RANGE_OFS   = 8'h04;
  localparam logic [7:0] CTA_PTHR_OFS    = 8'h08;
  localparam logic [7:0] CTA_OCTHR_OFS   = 8'h0c;
  localparam logic [7:0] CTA_LLCFG_OFS   = 8'h10;
  localparam logic [7:0] CTA_STATUS_OFS  = 8'h14;
  localparam logic [7:0] CTA_PVAL_OFS    = 8'h18;
  localparam logic [7:0] CTA_IOUT1_OFS   = 8'h1c;
  localparam logic [7:0] CTA_IOUT2_OFS   = 8'h20;
  localparam logic [2:0] CTA_GAIN_BLK    = 3'h2;
  localparam logic [2:0] CTA_OFS_BLK     = 3'h3;
  localparam logic [2:0] CTA_PHI_BLK     = 3'h4;
  // Field positions
  localparam int CTA_CTRL_N1_LSB  = 0;
  localparam int CTA_CTRL_N2_LSB  = 4;
  localparam int CTA_CTRL_LLEN    = 6;
  localparam int CTA_LL_SCALE_LSB = 16;
  // Reset values
  localparam logic [6:0]  CTA_CTRL_RST  = 7'h48;
  localparam logic [1:0]  CTA_RANGE_RST = 2'h0;
  localparam logic [26:0] CTA_PTHR_RST  = 27'h7ff_ffff;
  localparam logic [31:0] CTA_OCTHR_RST = 32'hffff_ffff;
  localparam logic [23:0] CTA_LLCFG_RST = 24'h80_1020;
  // Clock and times
  localparam int CTA_CLK_HZ         = 10_000_000;
  localparam int CTA_ALERT_HOLD_MS  = 100;
  localparam int CTA_ALERT_HOLD_CYC = CTA_ALERT_HOLD_MS * (CTA_CLK_HZ / 1000);
  localparam int CTA_ALERT_LAG_US   = 300;
  localparam int CTA_ALERT_LAG_CYC  = CTA_ALERT_LAG_US * (CTA_CLK_HZ / 1_000_000);
  localparam int CTA_PIN_BW_HZ      = 2000;
  // Single pole: corner = fs / (2*pi*2^k), so 2^k is about fs / (6*bw)
  localparam int CTA_PIN_SH  = $clog2(CTA_CLK_HZ / (6 * CTA_PIN_BW_HZ));
  localparam int CTA_PH_SH   = 3;
  // Input current sense span and top full scale, each further range halves it
  localparam int CTA_IIN_SPAN_MV = 1250;
  localparam int CTA_IIN_FS_MA   = 62500;
  localparam int CTA_NPH         = 8;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
  } cta_avs_req_t;

  typedef struct packed {
    logic [7:0][12:0] trim;
    logic [2:0]       first_phase;
    logic             fast_active;
  } cta_bal_t;

  typedef enum logic [1:0] {
    CTA_AL_IDLE   = 2'b00,
    CTA_AL_ASSERT = 2'b01,
    CTA_AL_HOLD   = 2'b10
  } cta_alert_st_t;

  typedef struct packed {
    logic             en_s1;
    logic             en_s2;
    logic             en_q;
    logic [1:0]       rng;
    logic [6:0]       ctrl;
    logic [1:0]       rng_cfg;
    logic [26:0]      pthr;
    logic [31:0]      octhr;
    logic [23:0]      llcfg;
    logic [7:0][5:0]  gain;
    logic [7:0][11:0] ofs;
    logic             ack;
    logic [31:0]      rdata;
    logic [2:0]       mux_sel;
    logic [7:0][15:0] filt;
    logic [26:0]      pin_raw;
    logic [36:0]      pin_acc;
    cta_alert_st_t    al_st;
    logic [23:0]      hold_cnt;
    logic             alert_oe_n;
    logic [1:0]       oc;
    logic [1:0][15:0] iout;
    logic [1:0][15:0] droop;
    cta_bal_t         bal;
    logic [7:0]       pwm;
    logic [7:0]       pwm_oe_n;
  } cta_state_t;
endpackage

// File: testbench/cta_checker.sv
// Port-level assertions for the current telemetry and power alert block
`timescale 1ns/1ps
module cta_checker
  import cta_pkg::*;
#(parameter int HOLD_CYC = 50) (
  // Clock, reset and register bus
  input wire logic         i_ref_clk,
  input wire logic         i_rstn,
  input wire cta_avs_req_t i_avs,
  input wire logic [31:0]  o_avs_readdata,
  input wire logic         o_avs_waitrequest,
  // Controls and outputs
  input wire logic         i_en,
  input wire logic         i_ramp_active,
  input wire logic         i_mon_valid,
  input wire logic         i_fast_transient,
  input wire logic [7:0]   o_pwm_oe_n,
  input wire logic [2:0]   o_mux_sel,
  input wire cta_bal_t     o_bal,
  input wire logic         o_alert_o,
  input wire logic         o_alert_oe_n
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  // Counts how long the alert has been pulled low, for the release delay
  logic [23:0] low_cnt_r;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) low_cnt_r <= '0;
    else if (o_alert_oe_n) low_cnt_r <= '0;
    else low_cnt_r <= low_cnt_r + 24'h1;
  end
  sequence s_req;
    (i_avs.read || i_avs.write) && o_avs_waitrequest;
  endsequence
  sequence s_alert_on;
    $fell(o_alert_oe_n);
  endsequence
  property p_wait_idle;
    !(i_avs.read || i_avs.write) |-> !o_avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("waitrequest without request");
  property p_wait_bound;
    s_req |=> !o_avs_waitrequest;
  endproperty
  a_wait_bound: assert property (p_wait_bound) else $error("bus access not answered");
  property p_rdata_hold;
    !i_avs.read |=> $stable(o_avs_readdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved while idle");
  property p_pwm_dis;
    !i_en [*5] |-> o_pwm_oe_n == 8'hff;
  endproperty
  a_pwm_dis: assert property (p_pwm_dis) else $error("pwm driven while disabled");
  property p_pwm_ramp;
    !i_ramp_active [*2] |-> o_pwm_oe_n == 8'hff;
  endproperty
  a_pwm_ramp: assert property (p_pwm_ramp) else $error("pwm driven outside ramp");
  property p_alert_od;
    o_alert_o == 1'b0;
  endproperty
  a_alert_od: assert property (p_alert_od) else $error("alert drives high");
  property p_alert_min;
    s_alert_on |-> !o_alert_oe_n [*8];
  endproperty
  a_alert_min: assert property (p_alert_min) else $error("alert released early");
  property p_alert_hold;
    $rose(o_alert_oe_n) |-> low_cnt_r >= HOLD_CYC;
  endproperty
  a_alert_hold: assert property (p_alert_hold) else $error("alert hold too short");
  property p_mux_hold;
    !i_mon_valid |=> $stable(o_mux_sel);
  endproperty
  a_mux_hold: assert property (p_mux_hold) else $error("mux moved without sample");
  property p_mux_wrap;
    i_mon_valid && o_mux_sel == 3'h7 |=> o_mux_sel == 3'h0;
  endproperty
  a_mux_wrap: assert property (p_mux_wrap) else $error("mux did not wrap");
  property p_fast_end;
    !i_fast_transient [*2] |-> !o_bal.fast_active && o_bal.first_phase == 3'h0;
  endproperty
  a_fast_end: assert property (p_fast_end) else $error("firing order not restored");
endmodule
bind cta_top cta_checker #(.HOLD_CYC(HOLD_CYC)) u_chk (.i_ref_clk, .i_rstn, .i_avs,
  .o_avs_readdata, .o_avs_waitrequest, .i_en, .i_ramp_active, .i_mon_valid, .i_fast_transient,
  .o_pwm_oe_n, .o_mux_sel, .o_bal, .o_alert_o, .o_alert_oe_n);

// File: testbench/cta_host_model.sv
// Host side of the open-drain power alert line, with its pull-up
`timescale 1ns/1ps
module cta_host_model (
  input  wire logic i_alert_o,
  input  wire logic i_alert_oe_n,
  output logic      o_pin
);
  // The pull-up sets the level whenever the device lets go of the line
  assign o_pin = i_alert_oe_n ? 1'b1 : i_alert_o;
endmodule

// File: testbench/tb.sv
// Self-checking testbench of the current telemetry and power alert block
`timescale 1ns/1ps
module tb;
  import cta_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, en = 1'b0, ramp = 1'b0;
  logic mon_v = 1'b0, iin_v = 1'b0, fast = 1'b0;
  cta_avs_req_t avs = '0;
  logic [7:0] pwm_raw = 8'h00;
  logic [11:0] mon_code = 12'h000, iin_code = 12'h000, vin_code = 12'h000;
  logic [1:0][15:0] vref = {16'h0400, 16'h0300};
  logic [31:0] rdata, rd;
  logic waitreq, alert_o, alert_oe_n, pin;
  logic [7:0] pwm, pwm_oe_n;
  logic [2:0] mux_sel;
  logic [1:0][15:0] droop, iout;
  logic [1:0] oc;
  cta_bal_t bal;
  int n_fail = 0, cmp_count = 0, cyc = 0, n;
  always #50 clk = ~clk;
  cta_top #(.HOLD_CYC(50)) uut (.i_ref_clk(clk), .i_rstn(rstn), .i_avs(avs),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_en(en), .i_ramp_active(ramp),
    .i_pwm_raw(pwm_raw), .o_pwm(pwm), .o_pwm_oe_n(pwm_oe_n), .o_mux_sel(mux_sel),
    .i_mon_code(mon_code), .i_mon_valid(mon_v), .i_iin_code(iin_code), .i_vin_code(vin_code),
    .i_iin_valid(iin_v), .i_fast_transient(fast), .i_voltage_setpoint_reference(vref),
    .o_droop_voltage_positioning(droop), .o_bal(bal), .o_oc(oc), .o_iout(iout),
    .o_alert_o(alert_o), .o_alert_oe_n(alert_oe_n));
  cta_host_model host (.i_alert_o(alert_o), .i_alert_oe_n(alert_oe_n), .o_pin(pin));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low; no latency is assumed
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    avs <= '{read: !wr, write: wr, address: a, writedata: d};
    do begin
      @(posedge clk);
      k++;
    end while (waitreq !== 1'b0 && k < 64);
    rd = rdata;
    if (k >= 64) n_fail++;
    avs <= '0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic cycles(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic wait_pin(input logic v);
    n = 0;
    while (pin !== v && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic pulse_iin(input logic [11:0] c);
    iin_code <= c;
    iin_v <= 1'b1;
    @(posedge clk);
    iin_v <= 1'b0;
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      finish_test;
    end
  end
  initial begin
    cycles(16);
    rstn <= 1'b1;
    cycles(4);
    rdchk(CTA_CTRL_OFS, 32'h48);
    rdchk(CTA_RANGE_OFS, 32'h0);
    rdchk(CTA_PTHR_OFS, 32'h07ff_ffff);
    rdchk(CTA_OCTHR_OFS, 32'hffff_ffff);
    rdchk(CTA_LLCFG_OFS, 32'h0080_1020);
    bus(1'b1, 8'h3c, 32'h1234);
    rdchk(8'h3c, 32'h0);
    chk(32'(pwm_oe_n), 32'hff);
    // Phase 0 keeps part of its code, phase 1 offset swallows it all
    bus(1'b1, 8'h60, 32'h10);
    bus(1'b1, 8'h64, 32'h200);
    for (int i = 0; i < 8; i++) begin
      chk(32'(mux_sel), 32'(i));
      mon_code <= (i == 0) ? 12'h030 : 12'h100 + 12'(i);
      mon_v <= 1'b1;
      @(posedge clk);
      mon_v <= 1'b0;
      @(posedge clk);
    end
    chk(32'(mux_sel), 32'h0);
    rdchk(8'h80, 32'h40);
    rdchk(8'h84, 32'h0);
    for (int i = 2; i < 8; i++)
      rdchk(8'h80 + 8'(4 * i), 32'(2 * (256 + i)));
    bus(1'b1, CTA_RANGE_OFS, 32'h2);
    en <= 1'b1;
    ramp <= 1'b1;
    pwm_raw <= 8'h5a;
    cycles(6);
    chk(32'(pwm_oe_n), 32'h0);
    rdchk(CTA_STATUS_OFS, 32'h60);
    bus(1'b1, CTA_CTRL_OFS, 32'h64);
    cycles(2);
    chk(32'(pwm_oe_n), 32'hc0);
    chk(32'(bal.trim[7]), 32'h0);
    // Phase 1 gain of 6/32, loop 0 limit just under its true current
    bus(1'b1, 8'h44, 32'h6);
    bus(1'b1, CTA_OCTHR_OFS, 32'h0040_0040);
    cycles(2);
    chk(32'(pwm), 32'h5a);
    chk(32'(iout), 32'h0040_0044);
    chk(32'(droop), 32'h0408_0311);
    chk(32'(oc), 32'h1);
    chk(32'(bal.trim[0]), 32'hd);
    chk(32'(bal.trim[1]), 32'h14);
    rdchk(CTA_IOUT2_OFS, 32'h40);
    fast <= 1'b1;
    cycles(3);
    chk(32'(bal.fast_active), 32'h1);
    chk(32'(bal.first_phase), 32'h1);
    fast <= 1'b0;
    ramp <= 1'b0;
    cycles(3);
    chk(32'(bal.first_phase), 32'h0);
    chk(32'(pwm_oe_n), 32'hff);
    ramp <= 1'b1;
    bus(1'b1, CTA_RANGE_OFS, 32'h3);
    rdchk(CTA_RANGE_OFS, 32'h3);
    rdchk(CTA_STATUS_OFS, 32'h62);
    // Raw power is four times the threshold; the filter delays the crossing
    bus(1'b1, CTA_PTHR_OFS, 32'h0008_0000);
    vin_code <= 12'h400;
    pulse_iin(12'h400);
    cycles(100);
    chk(32'(pin), 32'h1);
    wait_pin(1'b0);
    chk(32'(pin), 32'h0);
    chk(32'(n + 100 <= CTA_ALERT_LAG_CYC), 32'h1);
    cycles(2500);
    pulse_iin(12'h000);
    // Filtered power now sits between ninety percent and the threshold
    cycles(1400);
    chk(32'(pin), 32'h0);
    wait_pin(1'b1);
    chk(32'(pin), 32'h1);
    chk(32'(n >= 50), 32'h1);
    finish_test;
  end
endmodule
